// ==== src/e1li_top.v ====
`timescale 1ns/10ps
`include "e1li_consts.vh"

module e1li_top (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Interrupt
  output wire irq,
  // Receive line pins
  input wire receive_line_pos,
  input wire receive_line_neg,
  // Receive user side
  output reg recovered_clock_out,
  output reg rx_data,
  output reg rx_strobe,
  output wire carrier_loss,
  // Transmit user side
  input wire tx_data,
  input wire tx_strobe,
  // Transmit line pins
  output reg transmit_line_pos,
  output reg transmit_line_neg,
  output wire transmit_line_pos_oe,
  output wire transmit_line_neg_oe,
  // Analog controls
  output wire [2:0] build_out,
  output wire receive_gain_limit
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [1:0] pos_sync;
  reg [1:0] neg_sync;
  reg [7:0] line_interface_control;
  reg [1:0] status;
  reg [1:0] mask;
  reg loss_d;
  reg [3:0] mclk_cnt;
  reg master_clk;
  reg [6:0] wptr;
  reg [6:0] rptr;
  reg [4:0] div_cnt;
  reg [4:0] div_len;
  reg smooth_clk;
  reg rd_pend;
  reg ja_strobe;
  reg ami_pol;
  reg [3:0] pulse_cnt;
  wire ja_bit;
  wire cdr_strobe;
  wire cdr_data;
  wire rclk_raw;
  wire hit;
  wire wr_acc;
  wire pwr_down;
  wire ja_off;
  wire ja_tx;
  wire depth_small;
  wire ja_rx;
  wire ja_in_strobe;
  wire ja_in_bit;
  wire rd_tick;
  wire [6:0] diff;
  wire [6:0] fill;
  wire [6:0] half;
  wire [6:0] lim;
  wire over_hi;
  wire over_lo;
  wire trip;
  wire loss_rise;
  wire [1:0] events;
  wire tx_bit_strobe;
  wire tx_bit;
  wire [31:0] rd_mux;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  // All three sections are driven from the one register
  assign pwr_down = line_interface_control[`E1LI_BIT_PWRDN];
  assign ja_off = line_interface_control[`E1LI_BIT_JAOFF];
  assign depth_small = line_interface_control[`E1LI_BIT_DEPTH];
  assign ja_tx = line_interface_control[`E1LI_BIT_SIDE];
  assign receive_gain_limit = line_interface_control[`E1LI_BIT_GAIN];
  assign build_out = line_interface_control[`E1LI_LBO_MSB:`E1LI_LBO_LSB];
  assign ja_rx = ~ja_off & ~ja_tx;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_sync <= 2'b00;
      neg_sync <= 2'b00;
    end else if (ce) begin
      pos_sync <= {pos_sync[0], receive_line_pos};
      neg_sync <= {neg_sync[0], receive_line_neg};
    end
  end

  // ----------------------------------------
  // Clock and data recovery
  // ----------------------------------------
  e1li_cdr u_cdr (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pos_s(pos_sync[1]),
    .neg_s(neg_sync[1]),
    .bit_strobe(cdr_strobe),
    .bit_data(cdr_data),
    .rclk_raw(rclk_raw),
    .carrier_loss(carrier_loss)
  );

  // ----------------------------------------
  // Master clock, the oversample clock over 16
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_cnt <= 4'h0;
      master_clk <= 1'b0;
    end else if (ce) begin
      mclk_cnt <= mclk_cnt + 4'h1;
      master_clk <= (mclk_cnt < `E1LI_SAMPLE_PH);
    end
  end

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  assign hit = (paddr == `E1LI_OFS_CTRL) || (paddr == `E1LI_OFS_STAT) ||
               (paddr == `E1LI_OFS_MASK) || (paddr == `E1LI_OFS_INFO);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_acc = psel & penable & pwrite & hit & ce;

  assign rd_mux = (paddr == `E1LI_OFS_CTRL) ? {24'h000000, line_interface_control} :
                  (paddr == `E1LI_OFS_STAT) ? {30'h00000000, status} :
                  (paddr == `E1LI_OFS_MASK) ? {30'h00000000, mask} :
                  (paddr == `E1LI_OFS_INFO) ? {17'h00000, fill, 7'h00, carrier_loss} :
                  32'h00000000;

  // Read data is caught in the setup cycle so it leaves a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_interface_control <= `E1LI_CTRL_RST;
      mask <= `E1LI_MASK_RST;
    end else if (wr_acc) begin
      if (paddr == `E1LI_OFS_CTRL) begin
        line_interface_control <= pwdata[7:0];
      end
      if (paddr == `E1LI_OFS_MASK) begin
        mask <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Sticky status, write one to clear
  // ----------------------------------------
  assign loss_rise = carrier_loss & ~loss_d;
  assign events = {loss_rise, trip};

  // A new event in the clearing cycle wins over the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `E1LI_STAT_RST;
      loss_d <= 1'b1;
    end else if (ce) begin
      loss_d <= carrier_loss;
      if (wr_acc && paddr == `E1LI_OFS_STAT) begin
        status <= (status & ~pwdata[1:0]) | events;
      end else begin
        status <= status | events;
      end
    end
  end

  assign irq = |(status & mask);

  // ----------------------------------------
  // Jitter attenuator
  // ----------------------------------------
  assign ja_in_strobe = ~ja_off & (ja_tx ? tx_strobe : cdr_strobe);
  assign ja_in_bit = ja_tx ? tx_data : cdr_data;
  assign rd_tick = ~ja_off & (div_cnt == div_len - 5'h01);
  assign diff = wptr - rptr;
  // Addresses wrap at 32 in the short mode, so the fill wraps likewise
  assign fill = depth_small ? {2'b00, diff[4:0]} : diff;
  assign half = depth_small ? `E1LI_HALF_SMALL : `E1LI_HALF_BIG;
  assign lim = depth_small ? `E1LI_LIM_SMALL : `E1LI_LIM_BIG;
  assign over_hi = fill >= half + lim;
  assign over_lo = fill <= half - lim;
  assign trip = rd_tick & (over_hi | over_lo);

  e1li_bitmem u_mem (
    .pclk(pclk),
    .ce(ce),
    .wr_en(ja_in_strobe),
    .wr_addr(depth_small ? {2'b00, wptr[4:0]} : wptr),
    .wr_bit(ja_in_bit),
    .rd_en(rd_tick),
    .rd_addr(depth_small ? {2'b00, rptr[4:0]} : rptr),
    .rd_bit(ja_bit)
  );

  // A control write recentres the buffer, losing what it held
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= `E1LI_HALF_BIG;
      rptr <= 7'h00;
    end else if (ce) begin
      if (wr_acc && paddr == `E1LI_OFS_CTRL) begin
        wptr <= pwdata[`E1LI_BIT_DEPTH] ? `E1LI_HALF_SMALL : `E1LI_HALF_BIG;
        rptr <= 7'h00;
      end else begin
        if (ja_in_strobe) begin
          wptr <= wptr + 7'h01;
        end
        if (rd_tick) begin
          rptr <= rptr + 7'h01;
        end
      end
    end
  end

  // Smoothing divider: 16 normally, 15 or 17 to pull the fill back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 5'h00;
      div_len <= `E1LI_DIV_NORM;
      smooth_clk <= 1'b0;
      rd_pend <= 1'b0;
      ja_strobe <= 1'b0;
    end else if (ce) begin
      rd_pend <= rd_tick;
      ja_strobe <= rd_pend;
      smooth_clk <= (div_cnt < `E1LI_SMOOTH_HI);
      if (div_cnt == div_len - 5'h01) begin
        div_cnt <= 5'h00;
        if (over_hi) begin
          div_len <= `E1LI_DIV_FAST;
        end else if (over_lo) begin
          div_len <= `E1LI_DIV_SLOW;
        end else begin
          div_len <= `E1LI_DIV_NORM;
        end
      end else begin
        div_cnt <= div_cnt + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Receive outputs
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recovered_clock_out <= 1'b0;
      rx_data <= 1'b0;
      rx_strobe <= 1'b0;
    end else if (ce) begin
      if (carrier_loss) begin
        recovered_clock_out <= master_clk;
      end else if (ja_rx) begin
        recovered_clock_out <= smooth_clk;
      end else begin
        recovered_clock_out <= rclk_raw;
      end
      rx_strobe <= ja_rx ? ja_strobe : cdr_strobe;
      if (ja_rx ? ja_strobe : cdr_strobe) begin
        rx_data <= ja_rx ? ja_bit : cdr_data;
      end
    end
  end

  // ----------------------------------------
  // Transmitter, alternate mark encoding
  // ----------------------------------------
  assign tx_bit_strobe = (~ja_off & ja_tx) ? ja_strobe : tx_strobe;
  assign tx_bit = (~ja_off & ja_tx) ? ja_bit : tx_data;
  // Powered down means both pins released
  assign transmit_line_pos_oe = ~pwr_down;
  assign transmit_line_neg_oe = ~pwr_down;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ami_pol <= 1'b0;
      pulse_cnt <= 4'h0;
      transmit_line_pos <= 1'b0;
      transmit_line_neg <= 1'b0;
    end else if (ce) begin
      if (pwr_down) begin
        pulse_cnt <= 4'h0;
        transmit_line_pos <= 1'b0;
        transmit_line_neg <= 1'b0;
      end else if (tx_bit_strobe && tx_bit) begin
        ami_pol <= ~ami_pol;
        pulse_cnt <= `E1LI_AMI_PULSE - 4'h1;
        transmit_line_pos <= ~ami_pol;
        transmit_line_neg <= ami_pol;
      end else if (pulse_cnt != 4'h0) begin
        pulse_cnt <= pulse_cnt - 4'h1;
      end else begin
        transmit_line_pos <= 1'b0;
        transmit_line_neg <= 1'b0;
      end
    end
  end

endmodule // e1li_top

// ==== src/e1li_consts.vh ====
`ifndef E1LI_CONSTS_VH
`define E1LI_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define E1LI_OFS_CTRL 12'h018
`define E1LI_OFS_STAT 12'h040
`define E1LI_OFS_MASK 12'h044
`define E1LI_OFS_INFO 12'h048

// ----------------------------------------
// Reset values
// ----------------------------------------
`define E1LI_CTRL_RST 8'h00
`define E1LI_STAT_RST 2'h0
`define E1LI_MASK_RST 2'h0

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define E1LI_BIT_PWRDN 0
`define E1LI_BIT_JAOFF 1
`define E1LI_BIT_DEPTH 2
`define E1LI_BIT_SIDE 3
`define E1LI_BIT_GAIN 4
`define E1LI_LBO_LSB 5
`define E1LI_LBO_MSB 7

// ----------------------------------------
// Status and info fields
// ----------------------------------------
`define E1LI_ST_TRIP 0
`define E1LI_ST_LOSS 1
`define E1LI_INFO_LOSS 0
`define E1LI_INFO_FILL_LSB 8

// ----------------------------------------
// Timing counts, in oversample ticks or bits
// ----------------------------------------
`define E1LI_OVS 5'h10
`define E1LI_DIV_NORM 5'h10
`define E1LI_DIV_FAST 5'h0F
`define E1LI_DIV_SLOW 5'h11
`define E1LI_SAMPLE_PH 4'h8
`define E1LI_RCLK_HI 4'h7
`define E1LI_SMOOTH_HI 5'h08
`define E1LI_LOSS_BITS 8'h20
`define E1LI_AMI_PULSE 4'h8

// ----------------------------------------
// Jitter buffer geometry
// ----------------------------------------
`define E1LI_HALF_BIG 7'h40
`define E1LI_HALF_SMALL 7'h10
`define E1LI_LIM_BIG 7'h3C
`define E1LI_LIM_SMALL 7'h0E

`endif

// ==== src/e1li_cdr.v ====
`timescale 1ns/10ps
`include "e1li_consts.vh"

module e1li_cdr (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // Synchronised line pair
  input wire pos_s,
  input wire neg_s,
  // Recovered stream
  output reg bit_strobe,
  output reg bit_data,
  output reg rclk_raw,
  output reg carrier_loss
);

  reg mark_d;
  reg seen;
  reg [3:0] phase;
  reg [7:0] quiet;
  wire mark;
  wire mark_rise;

  assign mark = pos_s | neg_s;
  assign mark_rise = mark & ~mark_d;

  // ----------------------------------------
  // Sixteen-tick oversampler
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mark_d <= 1'b0;
      seen <= 1'b0;
      phase <= 4'h0;
      quiet <= 8'h00;
      bit_strobe <= 1'b0;
      bit_data <= 1'b0;
      rclk_raw <= 1'b0;
      carrier_loss <= 1'b1;
    end else if (ce) begin
      mark_d <= mark;
      bit_strobe <= 1'b0;
      // Each mark re-aligns the bit phase, so pulses steer the clock
      if (mark_rise) begin
        phase <= 4'h1;
      end else begin
        phase <= phase + 4'h1;
      end
      // Digital recovery leaves the high phase one tick short
      rclk_raw <= (phase < `E1LI_RCLK_HI);
      if (phase == `E1LI_SAMPLE_PH) begin
        bit_strobe <= 1'b1;
        bit_data <= seen | mark_rise;
        seen <= 1'b0;
        if (seen | mark_rise) begin
          quiet <= 8'h00;
          carrier_loss <= 1'b0;
        end else if (quiet == `E1LI_LOSS_BITS) begin
          carrier_loss <= 1'b1;
        end else begin
          quiet <= quiet + 8'h01;
        end
      end else if (mark_rise) begin
        seen <= 1'b1;
      end
    end
  end

endmodule // e1li_cdr

// ==== src/e1li_bitmem.v ====
`timescale 1ns/10ps

module e1li_bitmem (
  // Clock
  input wire pclk,
  input wire ce,
  // Write port
  input wire wr_en,
  input wire [6:0] wr_addr,
  input wire wr_bit,
  // Registered read port
  input wire rd_en,
  input wire [6:0] rd_addr,
  output reg rd_bit
);

  reg mem [0:127];

  // No reset on the array; stale bits only leave after a refill
  always @(posedge pclk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_bit;
      end
      if (rd_en) begin
        rd_bit <= mem[rd_addr];
      end
    end
  end

endmodule // e1li_bitmem

// ==== test/e1li_top_sva.sv ====
`timescale 1ns/10ps
`include "e1li_consts.vh"

module e1li_top_sva (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // Line side
  input wire receive_line_pos,
  input wire receive_line_neg,
  input wire recovered_clock_out,
  input wire rx_strobe,
  input wire carrier_loss,
  input wire transmit_line_pos,
  input wire transmit_line_neg,
  input wire transmit_line_pos_oe,
  input wire transmit_line_neg_oe,
  input wire [2:0] build_out,
  input wire receive_gain_limit
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire ctl_wr = psel && penable && pwrite && pready && ce && (paddr == `E1LI_OFS_CTRL);
  wire [2:0] wr_lbo = pwdata[7:5];
  wire wr_gain = pwdata[4];
  wire wr_pd = pwdata[0];
  // Cycles since the last line mark, saturating
  reg [9:0] quiet_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      quiet_cnt <= 10'h000;
    else if (receive_line_pos || receive_line_neg)
      quiet_cnt <= 10'h000;
    else if (quiet_cnt != 10'h3FF)
      quiet_cnt <= quiet_cnt + 10'h001;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  chk_ctl_fields: assert property (ctl_wr |=>
    build_out == $past(wr_lbo) && receive_gain_limit == $past(wr_gain) && transmit_line_pos_oe == !$past(wr_pd))
    else $error("control fields not applied");
  chk_oe_cause: assert property ($changed(transmit_line_pos_oe) |-> $past(ctl_wr))
    else $error("output enable changed without write");
  // Pins are registered, so they may trail the enable by one cycle
  chk_oe_float: assert property (!transmit_line_pos_oe |-> !transmit_line_neg_oe &&
    ($past(transmit_line_pos_oe) || !transmit_line_pos && !transmit_line_neg))
    else $error("transmit pins active in power-down");
  chk_mark_width: assert property (disable iff (!presetn || !transmit_line_pos_oe)
    $rose(transmit_line_pos) |-> transmit_line_pos [*8] ##1 !transmit_line_pos && !transmit_line_neg)
    else $error("transmit mark width wrong");
  chk_strobe_once: assert property (disable iff (!presetn || !ce) rx_strobe |=> !rx_strobe)
    else $error("rx strobe longer than a cycle");
  chk_loss_set: assert property ($rose(carrier_loss) |-> quiet_cnt > 10'h1E0)
    else $error("carrier loss while marks present");
  chk_loss_clear: assert property ($fell(carrier_loss) |-> quiet_cnt < 10'h028)
    else $error("carrier loss cleared without mark");
  chk_master_clk: assert property (disable iff (!presetn || !carrier_loss || !ce)
    $rose(recovered_clock_out) && $past(carrier_loss, 16) |->
    recovered_clock_out [*8] ##1 !recovered_clock_out [*8] ##1 recovered_clock_out)
    else $error("master clock shape wrong");

  cov_loss_gone: cover property ($fell(carrier_loss));
  cov_neg_mark: cover property ($rose(transmit_line_neg));
  cov_unmapped: cover property (pslverr);
endmodule // e1li_top_sva

bind e1li_top e1li_top_sva chk_i (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .receive_line_pos(receive_line_pos), .receive_line_neg(receive_line_neg),
  .recovered_clock_out(recovered_clock_out), .rx_strobe(rx_strobe), .carrier_loss(carrier_loss),
  .transmit_line_pos(transmit_line_pos), .transmit_line_neg(transmit_line_neg),
  .transmit_line_pos_oe(transmit_line_pos_oe), .transmit_line_neg_oe(transmit_line_neg_oe),
  .build_out(build_out), .receive_gain_limit(receive_gain_limit));

// ==== test/e1li_line_model.sv ====
`timescale 1ns/10ps

module e1li_line_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bench control
  input wire active,
  input wire [4:0] period,
  // Receive pair of the block
  output reg line_pos,
  output reg line_neg
);
  reg [4:0] ph;
  reg pol;
  // All-ones AMI, half-bit marks; silence means no marks at all
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 5'h00;
      pol <= 1'b0;
      line_pos <= 1'b0;
      line_neg <= 1'b0;
    end else if (!active) begin
      ph <= 5'h00;
      line_pos <= 1'b0;
      line_neg <= 1'b0;
    end else begin
      ph <= (ph + 5'h01 >= period) ? 5'h00 : ph + 5'h01;
      if (ph + 5'h01 >= period)
        pol <= !pol;
      line_pos <= (ph < (period >> 1)) && pol;
      line_neg <= (ph < (period >> 1)) && !pol;
    end
  end
endmodule // e1li_line_model

// ==== test/test_e1_line_interface_control.sv ====
`timescale 1ns/10ps
`include "e1li_consts.vh"

module test_e1_line_interface_control;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg ce = 1'b1;
  reg [11:0] paddr = 12'h000;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] pwdata = 32'h0;
  reg tx_data = 1'b0;
  reg tx_strobe = 1'b0;
  reg line_on = 1'b0;
  reg [4:0] line_period = 5'h10;
  wire [31:0] prdata;
  wire pready, pslverr, irq, rpos, rneg, rco, rx_data, rx_strobe, carrier_loss;
  wire tpos, tneg, tpos_oe, tneg_oe, rgl;
  wire [2:0] build_out;
  integer num_errors = 0;
  integer n_checks = 0;
  integer i, n, j;
  reg [31:0] rd, wv;
  reg err, hit;

  always #50 pclk = ~pclk;

  e1li_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .receive_line_pos(rpos), .receive_line_neg(rneg), .recovered_clock_out(rco), .rx_data(rx_data),
    .rx_strobe(rx_strobe), .carrier_loss(carrier_loss), .tx_data(tx_data), .tx_strobe(tx_strobe),
    .transmit_line_pos(tpos), .transmit_line_neg(tneg), .transmit_line_pos_oe(tpos_oe),
    .transmit_line_neg_oe(tneg_oe), .build_out(build_out), .receive_gain_limit(rgl));

  e1li_line_model line (.pclk(pclk), .presetn(presetn), .active(line_on), .period(line_period),
    .line_pos(rpos), .line_neg(rneg));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input [31:0] got, input [31:0] exp, input string what);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH at %0t: %0s got %0h expected %0h", $time, what, got, exp);
      end
    end
  endtask

  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
        @(posedge pclk);
        k = k + 1;
      end
      check(k, 0, "apb answer");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // High run of the recovered clock, in cycles
  task hi_run(output integer h);
    integer k;
    begin
      h = 0;
      k = 0;
      while (rco !== 1'b0 && k < 64) begin
        @(negedge pclk);
        k = k + 1;
      end
      while (rco !== 1'b1 && k < 64) begin
        @(negedge pclk);
        k = k + 1;
      end
      while (rco === 1'b1 && h < 64) begin
        @(negedge pclk);
        h = h + 1;
      end
    end
  endtask

  // Strobe taken at the next edge; pins sampled half a cycle later
  task send_tx(input b);
    begin
      @(posedge pclk);
      tx_strobe <= 1'b1;
      tx_data <= b;
      @(posedge pclk);
      tx_strobe <= 1'b0;
      @(negedge pclk);
    end
  endtask

  task wait_loss(input v);
    begin
      n = 0;
      while (carrier_loss !== v && n < 2000) begin
        @(negedge pclk);
        n = n + 1;
      end
      check({31'h0, carrier_loss}, {31'h0, v}, "carrier loss");
    end
  endtask

  task trip_run(input [7:0] ctl, input [4:0] per, input exp);
    begin
      line_period <= per;
      apb(1'b1, `E1LI_OFS_CTRL, {24'h0, ctl});
      repeat (64) @(posedge pclk);
      apb(1'b1, `E1LI_OFS_STAT, 32'h1);
      hit = 1'b0;
      for (j = 0; j < 30; j = j + 1) begin
        repeat (200) @(posedge pclk);
        apb(1'b0, `E1LI_OFS_STAT, 32'h0);
        hit = hit | rd[0];
      end
      check({31'h0, hit}, {31'h0, exp}, "jitter trip");
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `E1LI_OFS_CTRL, 32'h0);
    check(rd, {24'h0, `E1LI_CTRL_RST}, "control reset");
    apb(1'b0, `E1LI_OFS_INFO, 32'h0);
    check({31'h0, rd[0]}, 32'h1, "loss after reset");
    $display("test reset_values done");
    for (i = 0; i < 8; i = i + 1) begin
      wv = {24'h0, i[2:0], i[0], 3'h0, i[1]};
      apb(1'b1, `E1LI_OFS_CTRL, wv);
      apb(1'b0, `E1LI_OFS_CTRL, 32'h0);
      check(rd, wv, "control readback");
      check({29'h0, build_out}, {29'h0, wv[7:5]}, "build out");
      check({31'h0, rgl}, {31'h0, wv[4]}, "gain limit");
      check({30'h0, tpos_oe, tneg_oe}, {30'h0, ~wv[0], ~wv[0]}, "tx enable");
    end
    apb(1'b1, 12'h0FC, 32'hFF);
    check({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, 12'h0FC, 32'h0);
    check({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b0, `E1LI_OFS_CTRL, 32'h0);
    check(rd, 32'hF1, "control kept");
    // Enable low must swallow the write
    ce <= 1'b0;
    apb(1'b1, `E1LI_OFS_CTRL, 32'h2);
    ce <= 1'b1;
    apb(1'b0, `E1LI_OFS_CTRL, 32'h0);
    check(rd, 32'hF1, "frozen write ignored");
    $display("test control_fields done");
    send_tx(1'b1);
    check({28'h0, tpos, tneg, tpos_oe, tneg_oe}, 32'h0, "powered down");
    apb(1'b1, `E1LI_OFS_CTRL, 32'h2);
    send_tx(1'b1);
    check({30'h0, tpos, tneg}, 32'h2, "first mark");
    repeat (14) @(posedge pclk);
    send_tx(1'b0);
    check({30'h0, tpos, tneg}, 32'h0, "space");
    repeat (14) @(posedge pclk);
    send_tx(1'b1);
    check({30'h0, tpos, tneg}, 32'h1, "second mark");
    $display("test transmit done");
    hi_run(n);
    check(n, 8, "master clock high");
    line_on <= 1'b1;
    wait_loss(1'b0);
    repeat (64) @(posedge pclk);
    for (i = 0; i < 8; i = i + 1) begin
      n = 0;
      while (rx_strobe !== 1'b1 && n < 40) begin
        @(negedge pclk);
        n = n + 1;
      end
      check({31'h0, rx_data}, 32'h1, "rx data");
      @(negedge pclk);
    end
    hi_run(n);
    check(n, 7, "raw clock high");
    apb(1'b1, `E1LI_OFS_CTRL, 32'h8);
    repeat (64) @(posedge pclk);
    hi_run(n);
    check(n, 7, "tx side clock high");
    apb(1'b1, `E1LI_OFS_CTRL, 32'h0);
    repeat (64) @(posedge pclk);
    hi_run(n);
    check(n, 8, "smoothed clock high");
    $display("test recovery done");
    trip_run(8'h04, 5'h0F, 1'b1);
    trip_run(8'h04, 5'h11, 1'b1);
    trip_run(8'h00, 5'h11, 1'b0);
    trip_run(8'h04, 5'h10, 1'b0);
    trip_run(8'h06, 5'h0F, 1'b0);
    $display("test jitter done");
    apb(1'b1, `E1LI_OFS_STAT, 32'h3);
    line_on <= 1'b0;
    wait_loss(1'b1);
    apb(1'b0, `E1LI_OFS_STAT, 32'h0);
    @(negedge pclk);
    check({30'h0, rd[1], irq}, 32'h2, "loss event unmasked");
    apb(1'b1, `E1LI_OFS_MASK, 32'h2);
    @(negedge pclk);
    check({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, `E1LI_OFS_STAT, 32'h2);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    $display("test interrupt done");
    end_sim;
  end

  initial begin
    repeat (80000) @(posedge pclk);
    num_errors = num_errors + 1;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_sim;
  end
endmodule // test_e1_line_interface_control
